// *** rtl/usbspc_pkg.sv ***
// Package for the USB suspend and power control block.
// Assumes a 100 MHz system clock; all timing counts derive from it.
package usbspc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int IDLE_SUSPEND_US = 3000;
	localparam int WAKE_MIN_SUSP_US = 5000;
	localparam int WAKE_DRIVE_US = 2000;
	localparam int IDLE_CYC = IDLE_SUSPEND_US * CLK_MHZ;
	localparam int WAKE_MIN_CYC = WAKE_MIN_SUSP_US * CLK_MHZ;
	localparam int WAKE_DRIVE_CYC = WAKE_DRIVE_US * CLK_MHZ;
	localparam int CNT_W = 20;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		USBSPC_DETACHED,
		USBSPC_ACTIVE,
		USBSPC_SUSPENDED,
		USBSPC_WAKING
	} usbspc_state_t;

	// Device-side USB context kept across suspend.
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] cfg;
		logic [15:0] ep_halt;
	} usbspc_ctx_t;

	// Events that justify a remote wake-up.
	typedef struct packed {
		logic incoming_call;
		logic unsolicited_msg;
		logic socket_data;
	} usbspc_wake_ev_t;

endpackage

// *** rtl/usbspc_sync.sv ***
// Three-flop input synchroniser with agreement filter.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/100ps
module usbspc_sync
	import usbspc_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] out_next;

	if (WIDTH < 1)
	begin : g_bad_width
		$error("usbspc_sync: width must be at least one");
	end

	// ----------------------------------------------------------------
	// Per-bit filter: a change counts only once stages two and three agree.
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			assign out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i]
				: sync_out[i];
		end
	endgenerate

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			sync_out <= '0;
		end
		else
		begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			sync_out <= out_next;
		end
	end
endmodule

// *** rtl/usbspc_ctrl.sv ***
// USB device-port suspend, resume, remote wake-up and detach control.
// Assumes the USB core reports line state changes and activity on mclk,
// and that vbus_sense_in and hub_port_en arrive asynchronously.
//
// Notes on behaviour
// - Enter suspend after bus idle period.
// - Hold device context unchanged while suspended.
// - Hub port disabled forces selective suspend.
// - Suspended plus power saving allows low-power idle.
// - Bus activity ends suspend immediately while the hub port is enabled.
// - Active unsuspended port stays ready, overriding saving.
// - Drive remote wake-up on internal events.
// - VBUS falling then low disables interface.
// - Interface enabled only while VBUS valid.
`timescale 1ns/100ps
module usbspc_ctrl
	import usbspc_pkg::*;
#(
	parameter int IDLE_CYCLES = IDLE_CYC,
	parameter int WAKE_MIN_CYCLES = WAKE_MIN_CYC,
	parameter int WAKE_DRIVE_CYCLES = WAKE_DRIVE_CYC
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic vbus_sense_in,
	input wire logic hub_port_en,
	input wire logic bus_state_change,
	input wire logic power_saving_setting,
	input wire logic remote_wake_en,
	input wire usbspc_wake_ev_t wake_ev,
	input wire logic work_pending,
	input wire logic ctx_wr,
	input wire usbspc_ctx_t ctx_in,
	output usbspc_ctx_t ctx_out,
	output usbspc_state_t state_out,
	output logic usb_enable,
	output logic suspended,
	output logic low_power_idle,
	output logic usb_ready,
	output logic remote_wake_drive
);
	// Counters are CNT_W bits wide; larger counts could never be reached.
	if (IDLE_CYCLES < 1 || IDLE_CYCLES >= (1 << CNT_W) ||
		WAKE_MIN_CYCLES < 1 || WAKE_MIN_CYCLES >= (1 << CNT_W) ||
		WAKE_DRIVE_CYCLES < 1 || WAKE_DRIVE_CYCLES >= (1 << CNT_W))
	begin : g_bad_count
		$error("usbspc_ctrl: count parameter out of range");
	end

	localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYCLES - 1);
	localparam logic [CNT_W-1:0] WMIN_LAST = CNT_W'(WAKE_MIN_CYCLES - 1);
	localparam logic [CNT_W-1:0] WDRV_LAST = CNT_W'(WAKE_DRIVE_CYCLES - 1);

	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	logic [1:0] pins_sync;
	logic vbus_ok;
	logic hub_ok;

	usbspc_sync #(.WIDTH(2)) u_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.async_in({hub_port_en, vbus_sense_in}),
		.sync_out(pins_sync)
	);
	assign vbus_ok = pins_sync[0];
	assign hub_ok = pins_sync[1];

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	usbspc_state_t state_reg, state_next;
	logic [CNT_W-1:0] idle_cnt_reg, idle_cnt_next;
	logic [CNT_W-1:0] susp_cnt_reg, susp_cnt_next;
	logic [CNT_W-1:0] drv_cnt_reg, drv_cnt_next;
	logic vbus_prev_reg;
	logic wake_pend_reg, wake_pend_next;
	usbspc_ctx_t ctx_reg, ctx_next;

	wire vbus_fall = vbus_prev_reg & ~vbus_ok;
	wire idle_done = (idle_cnt_reg == IDLE_LAST);
	wire susp_long = (susp_cnt_reg == WMIN_LAST);
	wire drv_done = (drv_cnt_reg == WDRV_LAST);
	wire any_ev = |wake_ev;
	wire in_susp = (state_reg == USBSPC_SUSPENDED);
	wire ctx_we = ctx_wr && (state_reg == USBSPC_ACTIVE);
	wire wake_go = in_susp && wake_pend_reg && remote_wake_en
		&& susp_long && !bus_state_change;

	// Counter restarts on any line change; saturates at the suspend limit.
	assign idle_cnt_next = (state_reg != USBSPC_ACTIVE || bus_state_change)
		? '0 : (idle_done ? idle_cnt_reg : idle_cnt_reg + 1'b1);
	assign susp_cnt_next = !in_susp ? '0
		: (susp_long ? susp_cnt_reg : susp_cnt_reg + 1'b1);
	assign drv_cnt_next = (state_reg == USBSPC_WAKING)
		? drv_cnt_reg + 1'b1 : '0;
	// New events win over the clear that the wake-up drive causes.
	// Events seen while detached are dropped, so none survives an attach.
	assign wake_pend_next = (state_reg != USBSPC_DETACHED)
		&& (any_ev || (wake_pend_reg && !wake_go));
	assign ctx_next = ctx_we ? ctx_in : ctx_reg;

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			USBSPC_DETACHED:
				if (vbus_ok)
					state_next = USBSPC_ACTIVE;
			USBSPC_ACTIVE:
				if (!hub_ok || idle_done)
					state_next = USBSPC_SUSPENDED;
			USBSPC_SUSPENDED:
				if (bus_state_change && hub_ok)
					state_next = USBSPC_ACTIVE;
				else if (wake_go)
					state_next = USBSPC_WAKING;
			USBSPC_WAKING:
				// The host answers with resume signalling of its own.
				if (drv_done)
					state_next = USBSPC_ACTIVE;
		endcase
		if (!vbus_ok || vbus_fall)
			state_next = USBSPC_DETACHED;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg <= USBSPC_DETACHED;
			idle_cnt_reg <= '0;
			susp_cnt_reg <= '0;
			drv_cnt_reg <= '0;
			vbus_prev_reg <= 1'b0;
			wake_pend_reg <= 1'b0;
			ctx_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			idle_cnt_reg <= idle_cnt_next;
			susp_cnt_reg <= susp_cnt_next;
			drv_cnt_reg <= drv_cnt_next;
			vbus_prev_reg <= vbus_ok;
			wake_pend_reg <= wake_pend_next;
			ctx_reg <= ctx_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign ctx_out = ctx_reg;
	assign state_out = state_reg;
	assign usb_enable = (state_reg != USBSPC_DETACHED);
	assign suspended = in_susp;
	assign usb_ready = (state_reg == USBSPC_ACTIVE);
	// Idle is dropped the moment any work or wake event shows up.
	assign low_power_idle = in_susp && power_saving_setting
		&& !work_pending && !any_ev;
	assign remote_wake_drive = (state_reg == USBSPC_WAKING);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_idle_suspend;
		@(posedge mclk) disable iff (sys_rst)
		(state_reg == USBSPC_ACTIVE && idle_done && vbus_ok && !vbus_fall)
		|=> in_susp;
	endproperty
	a_idle_suspend: assert property (p_idle_suspend)
		else $error("no suspend after idle period");

	property p_ctx_hold;
		@(posedge mclk) disable iff (sys_rst)
		in_susp |=> $stable(ctx_reg);
	endproperty
	a_ctx_hold: assert property (p_ctx_hold)
		else $error("context changed in suspend");

	property p_hub_off;
		@(posedge mclk) disable iff (sys_rst)
		(state_reg == USBSPC_ACTIVE && !hub_ok) |=> !usb_ready;
	endproperty
	a_hub_off: assert property (p_hub_off)
		else $error("hub disable did not suspend");

	property p_lpi;
		@(posedge mclk) disable iff (sys_rst)
		low_power_idle |-> (in_susp && power_saving_setting && !work_pending);
	endproperty
	a_lpi: assert property (p_lpi)
		else $error("low-power idle outside suspend");

	property p_resume;
		@(posedge mclk) disable iff (sys_rst)
		(in_susp && bus_state_change && hub_ok && vbus_ok && !vbus_fall)
		|=> usb_ready;
	endproperty
	a_resume: assert property (p_resume)
		else $error("bus activity did not resume");

	property p_wake_gate;
		@(posedge mclk) disable iff (sys_rst)
		$rose(remote_wake_drive) |-> $past(susp_long) && $past(remote_wake_en);
	endproperty
	a_wake_gate: assert property (p_wake_gate)
		else $error("wake-up drive without its conditions");

	property p_vbus_fall;
		@(posedge mclk) disable iff (sys_rst)
		vbus_fall |=> !usb_enable;
	endproperty
	a_vbus_fall: assert property (p_vbus_fall)
		else $error("interface stayed on after vbus fall");

	property p_vbus_low;
		@(posedge mclk) disable iff (sys_rst)
		!vbus_ok ##1 !vbus_ok |-> !usb_enable;
	endproperty
	a_vbus_low: assert property (p_vbus_low)
		else $error("interface on without vbus");

	c_suspend: cover property (@(posedge mclk) disable iff (sys_rst)
		$rose(suspended));
	c_wake: cover property (@(posedge mclk) disable iff (sys_rst)
		$rose(remote_wake_drive));
	c_lpi: cover property (@(posedge mclk) disable iff (sys_rst)
		$rose(low_power_idle));
endmodule

// *** sim/usbspc_host.sv ***
// Host side model: bus activity on request, resume burst after wake-up.
// Assumes the bench steers traffic_on just after mclk rising edges.
`timescale 1ns/100ps
module usbspc_host
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic traffic_on,
	input wire logic remote_wake_drive,
	output logic bus_state_change
);
	logic wake_reg;
	logic [3:0] resume_reg;

	// A real host resumes the bus once the device ends its wake drive.
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wake_reg <= 1'b0;
			resume_reg <= 4'h0;
			bus_state_change <= 1'b0;
		end
		else
		begin
			wake_reg <= remote_wake_drive;
			if (wake_reg && !remote_wake_drive)
				resume_reg <= 4'h8;
			else if (resume_reg != 4'h0)
				resume_reg <= resume_reg - 4'h1;
			bus_state_change <= traffic_on || resume_reg[0];
		end
	end
endmodule

// *** sim/usbspc_ctrl_test.sv ***
// Self-checking bench for the suspend and power control block.
// Assumes shortened timing parameters and the host model beside it.
`timescale 1ns/100ps
module usbspc_ctrl_test
	import usbspc_pkg::*;
;
	localparam int IDL = 20;
	localparam int WMIN = 30;
	localparam int WDRV = 5;
	localparam usbspc_ctx_t CTX = {7'h15, 8'h02, 16'hA5A5};
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic vbus_sense_in = 1'b0;
	logic hub_port_en = 1'b1;
	logic traffic_on = 1'b0;
	logic power_saving_setting = 1'b1;
	logic remote_wake_en = 1'b0;
	logic work_pending = 1'b0;
	logic ctx_wr = 1'b0;
	usbspc_wake_ev_t wake_ev = '0;
	usbspc_ctx_t ctx_in = '0;
	usbspc_ctx_t ctx_out;
	usbspc_state_t state_out;
	logic bus_state_change;
	logic usb_enable;
	logic suspended;
	logic low_power_idle;
	logic usb_ready;
	logic remote_wake_drive;
	int err_count = 0;
	int n_tests = 0;

	usbspc_ctrl #(.IDLE_CYCLES(IDL), .WAKE_MIN_CYCLES(WMIN),
		.WAKE_DRIVE_CYCLES(WDRV)) dut (.mclk, .sys_rst, .vbus_sense_in,
		.hub_port_en, .bus_state_change, .power_saving_setting,
		.remote_wake_en, .wake_ev, .work_pending, .ctx_wr, .ctx_in,
		.ctx_out, .state_out, .usb_enable, .suspended, .low_power_idle,
		.usb_ready, .remote_wake_drive);
	usbspc_host host (.mclk, .sys_rst, .traffic_on, .remote_wake_drive,
		.bus_state_change);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic pulse();
		@(posedge mclk) traffic_on <= 1'b1;
		@(posedge mclk) traffic_on <= 1'b0;
	endtask
	function automatic logic pick(input int s);
		return s == 0 ? suspended : s == 1 ? usb_enable : remote_wake_drive;
	endfunction
	// Bounded wait, so a stuck state ends in a mismatch, not a hang.
	task automatic wait_on(input int s, input logic v, output int n);
		n = 0;
		while (pick(s) !== v && n < 200)
		begin
			tick(1);
			n++;
		end
	endtask
	task automatic wr_ctx(input usbspc_ctx_t c);
		@(posedge mclk) ctx_in <= c;
		ctx_wr <= 1'b1;
		@(posedge mclk) ctx_wr <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_idle();
		int n;
		@(posedge mclk) vbus_sense_in <= 1'b1;
		tick(1);
		wait_on(1, 1'b1, n);
		chk("attach", n < 8, 1);
		chk("ready", usb_ready, 1);
		chk("lpi active", low_power_idle, 0);
		wr_ctx(CTX);
		repeat (3)
		begin
			pulse();
			tick(14);
		end
		chk("restart", suspended, 0);
		pulse();
		tick(1);
		wait_on(0, 1'b1, n);
		chk("idle span", n >= IDL-2 && n <= IDL+4, 1);
		chk("ready off", usb_ready, 0);
	endtask
	task automatic t_hold();
		int n;
		wr_ctx('0);
		tick(2);
		chk("ctx held", ctx_out, CTX);
		chk("lpi", low_power_idle, 1);
		@(posedge mclk) work_pending <= 1'b1;
		tick(1);
		chk("lpi busy", low_power_idle, 0);
		@(posedge mclk) work_pending <= 1'b0;
		power_saving_setting <= 1'b0;
		tick(1);
		chk("lpi off", low_power_idle, 0);
		@(posedge mclk) power_saving_setting <= 1'b1;
		pulse();
		tick(1);
		wait_on(0, 1'b0, n);
		chk("resume", n <= 2, 1);
		chk("ready back", usb_ready, 1);
		chk("ctx kept", ctx_out, CTX);
	endtask
	task automatic t_hub();
		int n;
		@(posedge mclk) hub_port_en <= 1'b0;
		traffic_on <= 1'b1;
		tick(1);
		wait_on(0, 1'b1, n);
		chk("hub off", n < 8, 1);
		@(posedge mclk) hub_port_en <= 1'b1;
		tick(8);
		chk("hub on", usb_ready, 1);
		@(posedge mclk) traffic_on <= 1'b0;
	endtask
	task automatic t_wake();
		int n;
		int d;
		logic seen;
		@(posedge mclk) remote_wake_en <= 1'b1;
		#1;
		for (int i = 0; i < 3; i++)
		begin
			wait_on(0, 1'b1, n);
			@(posedge mclk) wake_ev <= 3'h1 << i;
			#1;
			chk("lpi event", low_power_idle, 0);
			@(posedge mclk) wake_ev <= '0;
			tick(1);
			wait_on(2, 1'b1, n);
			chk("wake wait", n >= WMIN-4 && n <= WMIN+2, 1);
			wait_on(2, 1'b0, d);
			chk("wake drive", d, WDRV);
			chk("woken", usb_ready, 1);
		end
		@(posedge mclk) remote_wake_en <= 1'b0;
		#1;
		wait_on(0, 1'b1, n);
		@(posedge mclk) wake_ev <= 3'h4;
		@(posedge mclk) wake_ev <= '0;
		seen = 1'b0;
		repeat (50)
		begin
			tick(1);
			seen |= remote_wake_drive;
		end
		chk("wake barred", seen, 0);
		@(posedge mclk) vbus_sense_in <= 1'b0;
		tick(1);
		wait_on(1, 1'b0, n);
		chk("detach", n < 8, 1);
		chk("detached", state_out, USBSPC_DETACHED);
	endtask

	initial
	begin
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		#200000;
		err_count++;
		final_report();
	end
	initial
	begin
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		tick(2);
		chk("reset off", usb_enable, 0);
		chk("state reset", state_out, USBSPC_DETACHED);
		chk("ctx reset", ctx_out, 0);
		t_idle();
		t_hold();
		t_hub();
		t_wake();
		final_report();
	end
endmodule
